// ===== include/gob_pkg.sv
// package for the output / drive-enable register bank of 40 pads
// assumes a 32-bit apb slave; byte addresses equal printed offsets
package gob_pkg;
    localparam int unsigned GOB_DATA_W = 32;
    localparam int unsigned GOB_HI_W = 8;
    localparam int unsigned GOB_ADDR_W = 8;
    localparam int unsigned GOB_STRAP_W = 6;
    // register byte offsets
    localparam logic [7:0] GOB_OFS_LO_OUT = 8'h04;
    localparam logic [7:0] GOB_OFS_LO_OUT_SET = 8'h08;
    localparam logic [7:0] GOB_OFS_LO_OUT_CLR = 8'h0c;
    localparam logic [7:0] GOB_OFS_HI_OUT = 8'h10;
    localparam logic [7:0] GOB_OFS_HI_OUT_SET = 8'h14;
    localparam logic [7:0] GOB_OFS_HI_OUT_CLR = 8'h18;
    localparam logic [7:0] GOB_OFS_LO_OE = 8'h20;
    localparam logic [7:0] GOB_OFS_LO_OE_SET = 8'h24;
    localparam logic [7:0] GOB_OFS_LO_OE_CLR = 8'h28;
    localparam logic [7:0] GOB_OFS_HI_OE = 8'h2c;
    localparam logic [7:0] GOB_OFS_HI_OE_SET = 8'h30;
    localparam logic [7:0] GOB_OFS_HI_OE_CLR = 8'h34;
    localparam logic [7:0] GOB_OFS_STRAP = 8'h38;
    // reset values
    localparam logic [31:0] GOB_RST_LO = 32'h0000_0000;
    localparam logic [7:0] GOB_RST_HI = 8'h00;
    localparam logic [5:0] GOB_RST_STRAP = 6'h00;
    // strap field positions, bit 5 down to bit 0
    localparam int unsigned GOB_STRAP_TDI_POS = 5;
    localparam int unsigned GOB_STRAP_P0_POS = 4;
    localparam int unsigned GOB_STRAP_P2_POS = 3;
    localparam int unsigned GOB_STRAP_P4_POS = 2;
    localparam int unsigned GOB_STRAP_TDO_POS = 1;
    localparam int unsigned GOB_STRAP_P5_POS = 0;

    // apb request as seen by the slave
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } gob_apb_req_t;

    // how a write changes one target register
    typedef enum logic [1:0] {
        GOB_OP_NONE,
        GOB_OP_WRITE,
        GOB_OP_SET,
        GOB_OP_CLR
    } gob_op_t;
endpackage

// ===== rtl/gob_bank.sv
// output value and drive-enable registers for pads 0..39, apb slave
// assumes synchronous inputs on clk_i; straps are sampled once after reset
// every access is answered after exactly one wait state; a low clock enable
// holds a pending access, so the master simply sees a longer wait
// the pad levels and enables leave straight from flops, so the pad ring sees
// no decode glitches while software rewrites a companion register
//
// Contract
// R1: low output register at 0x04, bit n drives pad n level, pads 0-31.
// R2: write to 0x08 sets low output bits where data is one.
// R3: write to 0x0c clears low output bits where data is one.
// R4: high output register at 0x10, low eight bits drive pads 32-39.
// R5: write to 0x14 sets high output bits where data is one.
// R6: write to 0x18 clears high output bits where data is one.
// R7: low enable register at 0x20, bit n enables pad n driver.
// R8: write to 0x24 sets low enable bits where data is one.
// R9: write to 0x28 clears low enable bits where data is one.
// R10: high enable register at 0x2c controls drivers of pads 32-39.
// R11: write to 0x30 sets high enable bits where data is one.
// R12: write to 0x34 clears high enable bits where data is one.
// R13: strap register at 0x38 shows six latched boot-select pad levels.
// R14: set, clear and direct writes act as one atomic read-modify-write.
`timescale 1ns/10ps
module gob_bank
    import gob_pkg::*;
#(
    parameter int unsigned LO_W = GOB_DATA_W, // pads in the low bank
    parameter int unsigned HI_W = GOB_HI_W // pads in the high bank
) (
    input wire logic clk_i, // system clock, 25 MHz
    input wire logic rst_n_i, // synchronous reset, active low
    input wire logic ce_i, // clock enable, freezes all state when low
    input wire logic psel_i, // apb select
    input wire logic penable_i, // apb access phase
    input wire logic pwrite_i, // apb direction, high is write
    input wire logic [GOB_ADDR_W-1:0] paddr_i, // apb byte address
    input wire logic [31:0] pwdata_i, // apb write data
    output logic [31:0] prdata_o, // apb read data, registered
    output logic pready_o, // apb ready, registered
    output logic pslverr_o, // apb error on unmapped address
    input wire logic strap_tdi_i, // test data input pad level
    input wire logic strap_p0_i, // pad 0 level at boot
    input wire logic strap_p2_i, // pad 2 level at boot
    input wire logic strap_p4_i, // pad 4 level at boot
    input wire logic strap_tdo_i, // test data output pad level
    input wire logic strap_p5_i, // pad 5 level at boot
    output logic [LO_W-1:0] lo_out_o, // pad levels, pads 0-31
    output logic [LO_W-1:0] lo_oe_o, // driver enables, pads 0-31
    output logic [HI_W-1:0] hi_out_o, // pad levels, pads 32-39
    output logic [HI_W-1:0] hi_oe_o // driver enables, pads 32-39
);
    gob_apb_req_t req;
    logic [LO_W-1:0] lo_out_q, lo_out_d, lo_oe_q, lo_oe_d;
    logic [HI_W-1:0] hi_out_q, hi_out_d, hi_oe_q, hi_oe_d;
    logic [GOB_STRAP_W-1:0] strap_q, strap_d;
    logic strap_done_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;

    assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i, paddr: paddr_i, pwdata: pwdata_i};

    // the slave answers one cycle after the access phase starts; pready_q pulses in the access phase.
    // the access phase with pready_q low is the single cycle where a write lands.
    wire access_w = req.psel && req.penable && !pready_q;
    wire wr_w = access_w && req.pwrite;
    wire rd_w = access_w && !req.pwrite;

    // address decode
    wire hit_lo_out = (req.paddr == GOB_OFS_LO_OUT);
    wire hit_lo_out_set = (req.paddr == GOB_OFS_LO_OUT_SET);
    wire hit_lo_out_clr = (req.paddr == GOB_OFS_LO_OUT_CLR);
    wire hit_hi_out = (req.paddr == GOB_OFS_HI_OUT);
    wire hit_hi_out_set = (req.paddr == GOB_OFS_HI_OUT_SET);
    wire hit_hi_out_clr = (req.paddr == GOB_OFS_HI_OUT_CLR);
    wire hit_lo_oe = (req.paddr == GOB_OFS_LO_OE);
    wire hit_lo_oe_set = (req.paddr == GOB_OFS_LO_OE_SET);
    wire hit_lo_oe_clr = (req.paddr == GOB_OFS_LO_OE_CLR);
    wire hit_hi_oe = (req.paddr == GOB_OFS_HI_OE);
    wire hit_hi_oe_set = (req.paddr == GOB_OFS_HI_OE_SET);
    wire hit_hi_oe_clr = (req.paddr == GOB_OFS_HI_OE_CLR);
    wire hit_strap = (req.paddr == GOB_OFS_STRAP);
    wire mapped_w = hit_lo_out | hit_lo_out_set | hit_lo_out_clr | hit_hi_out | hit_hi_out_set
        | hit_hi_out_clr | hit_lo_oe | hit_lo_oe_set | hit_lo_oe_clr | hit_hi_oe | hit_hi_oe_set
        | hit_hi_oe_clr | hit_strap;

    // one apb access carries one address, so each register sees one op per cycle
    // and set, clear or plain write is a single read-modify-write
    wire [LO_W-1:0] wd_lo = req.pwdata[LO_W-1:0];
    wire [HI_W-1:0] wd_hi = req.pwdata[HI_W-1:0];

    // write strobes for the low output value and its companions
    wire wr_lo_out = wr_w && hit_lo_out;
    wire wr_lo_out_set = wr_w && hit_lo_out_set;
    wire wr_lo_out_clr = wr_w && hit_lo_out_clr;

    // write strobes for the high output value and its companions
    wire wr_hi_out = wr_w && hit_hi_out;
    wire wr_hi_out_set = wr_w && hit_hi_out_set;
    wire wr_hi_out_clr = wr_w && hit_hi_out_clr;

    // write strobes for the low drive enable and its companions
    wire wr_lo_oe = wr_w && hit_lo_oe;
    wire wr_lo_oe_set = wr_w && hit_lo_oe_set;
    wire wr_lo_oe_clr = wr_w && hit_lo_oe_clr;

    // write strobes for the high drive enable and its companions
    wire wr_hi_oe = wr_w && hit_hi_oe;
    wire wr_hi_oe_set = wr_w && hit_hi_oe_set;
    wire wr_hi_oe_clr = wr_w && hit_hi_oe_clr;

    // operation per register; the strobes exclude each other by address,
    // the priority order only keeps the decode free of a don't-care
    wire gob_op_t op_lo_out = wr_lo_out ? GOB_OP_WRITE
        : wr_lo_out_set ? GOB_OP_SET
        : wr_lo_out_clr ? GOB_OP_CLR
        : GOB_OP_NONE;

    wire gob_op_t op_hi_out = wr_hi_out ? GOB_OP_WRITE
        : wr_hi_out_set ? GOB_OP_SET
        : wr_hi_out_clr ? GOB_OP_CLR
        : GOB_OP_NONE;

    wire gob_op_t op_lo_oe = wr_lo_oe ? GOB_OP_WRITE
        : wr_lo_oe_set ? GOB_OP_SET
        : wr_lo_oe_clr ? GOB_OP_CLR
        : GOB_OP_NONE;

    wire gob_op_t op_hi_oe = wr_hi_oe ? GOB_OP_WRITE
        : wr_hi_oe_set ? GOB_OP_SET
        : wr_hi_oe_clr ? GOB_OP_CLR
        : GOB_OP_NONE;

    // next low output value; set and clear touch only the bits written as one,
    // so software may steer single pads without a read first
    always_comb begin
        lo_out_d = lo_out_q;
        case (op_lo_out)
            GOB_OP_WRITE: begin
                lo_out_d = wd_lo; // R1 R14
            end
            GOB_OP_SET: begin
                lo_out_d = lo_out_q | wd_lo; // R2 R14
            end
            GOB_OP_CLR: begin
                lo_out_d = lo_out_q & ~wd_lo; // R3 R14
            end
            default: begin
                lo_out_d = lo_out_q;
            end
        endcase
    end

    // next high output value; bits above the bank width are dropped
    always_comb begin
        hi_out_d = hi_out_q;
        case (op_hi_out)
            GOB_OP_WRITE: begin
                hi_out_d = wd_hi; // R4 R14
            end
            GOB_OP_SET: begin
                hi_out_d = hi_out_q | wd_hi; // R5 R14
            end
            GOB_OP_CLR: begin
                hi_out_d = hi_out_q & ~wd_hi; // R6 R14
            end
            default: begin
                hi_out_d = hi_out_q;
            end
        endcase
    end

    // next low drive enable
    always_comb begin
        lo_oe_d = lo_oe_q;
        case (op_lo_oe)
            GOB_OP_WRITE: begin
                lo_oe_d = wd_lo; // R7 R14
            end
            GOB_OP_SET: begin
                lo_oe_d = lo_oe_q | wd_lo; // R8 R14
            end
            GOB_OP_CLR: begin
                lo_oe_d = lo_oe_q & ~wd_lo; // R9 R14
            end
            default: begin
                lo_oe_d = lo_oe_q;
            end
        endcase
    end

    // next high drive enable; bits above the bank width are dropped
    always_comb begin
        hi_oe_d = hi_oe_q;
        case (op_hi_oe)
            GOB_OP_WRITE: begin
                hi_oe_d = wd_hi; // R10 R14
            end
            GOB_OP_SET: begin
                hi_oe_d = hi_oe_q | wd_hi; // R11 R14
            end
            GOB_OP_CLR: begin
                hi_oe_d = hi_oe_q & ~wd_hi; // R12 R14
            end
            default: begin
                hi_oe_d = hi_oe_q;
            end
        endcase
    end

    // strap levels in register order, bit 5 down to bit 0
    always_comb begin
        strap_d = strap_q;
        strap_d[GOB_STRAP_TDI_POS] = strap_tdi_i; // R13
        strap_d[GOB_STRAP_P0_POS] = strap_p0_i; // R13
        strap_d[GOB_STRAP_P2_POS] = strap_p2_i; // R13
        strap_d[GOB_STRAP_P4_POS] = strap_p4_i; // R13
        strap_d[GOB_STRAP_TDO_POS] = strap_tdo_i; // R13
        strap_d[GOB_STRAP_P5_POS] = strap_p5_i; // R13
    end

    // read data per source, zero-extended to the bus width;
    // the high bank and strap fields read zero above their width
    wire [31:0] rd_lo_out = 32'(lo_out_q);
    wire [31:0] rd_hi_out = 32'(hi_out_q);
    wire [31:0] rd_lo_oe = 32'(lo_oe_q);
    wire [31:0] rd_hi_oe = 32'(hi_oe_q);
    wire [31:0] rd_strap = 32'(strap_q);

    // read mux; write-only registers read as zero
    wire [31:0] rd_mux = hit_lo_out ? rd_lo_out
        : hit_hi_out ? rd_hi_out
        : hit_lo_oe ? rd_lo_oe
        : hit_hi_oe ? rd_hi_oe
        : hit_strap ? rd_strap
        : 32'h0000_0000;

    // apb answer next values; read data is zero outside the ready cycle
    // so a stale word can never be mistaken for a fresh one
    wire pready_d = access_w;
    wire pslverr_d = access_w && !mapped_w;
    wire [31:0] prdata_d = rd_w ? rd_mux : 32'h0000_0000;

    // low output value register, drives the levels of pads 0-31
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lo_out_q <= LO_W'(GOB_RST_LO);
        end else if (ce_i) begin
            lo_out_q <= lo_out_d;
        end
    end

    // low drive enable register, reset low so no pad drives before software asks
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lo_oe_q <= LO_W'(GOB_RST_LO);
        end else if (ce_i) begin
            lo_oe_q <= lo_oe_d;
        end
    end

    // high output value register, drives the levels of pads 32-39
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            hi_out_q <= HI_W'(GOB_RST_HI);
        end else if (ce_i) begin
            hi_out_q <= hi_out_d;
        end
    end

    // high drive enable register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            hi_oe_q <= HI_W'(GOB_RST_HI);
        end else if (ce_i) begin
            hi_oe_q <= hi_oe_d;
        end
    end

    // strap latch: caught once on the first enabled edge after reset release,
    // so the pads may later be reused as outputs without disturbing it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            strap_q <= GOB_RST_STRAP;
            strap_done_q <= 1'b0;
        end else if (ce_i && !strap_done_q) begin
            strap_q <= strap_d; // R13
            strap_done_q <= 1'b1;
        end
    end

    // apb ready, one wait state so every answer leaves a flop
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pready_q <= 1'b0;
        end else if (ce_i) begin
            pready_q <= pready_d;
        end
    end

    // apb error, raised with ready for an address that maps to nothing
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pslverr_q <= 1'b0;
        end else if (ce_i) begin
            pslverr_q <= pslverr_d;
        end
    end

    // apb read data, held for the ready cycle only
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (ce_i) begin
            prdata_q <= prdata_d;
        end
    end

    // outputs straight from the registers
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign lo_out_o = lo_out_q;
    assign lo_oe_o = lo_oe_q;
    assign hi_out_o = hi_out_q;
    assign hi_oe_o = hi_oe_q;
endmodule

// ===== test/gob_pad_model.sv
// pads around the output bank, with weak pull-downs
// assumes boot strap levels are fixed for the whole run
`timescale 1ns/10ps
module gob_pad_model #(
    parameter logic [5:0] STRAP = 6'h2d // boot levels, strap register order
) (
    input wire logic [31:0] lo_out_i, // levels 0-31
    input wire logic [31:0] lo_oe_i, // enables 0-31
    input wire logic [7:0] hi_out_i, // levels 32-39
    input wire logic [7:0] hi_oe_i, // enables 32-39
    output logic [39:0] pad_o, // resolved pad levels
    output logic [5:0] strap_o // boot levels
);
    // an undriven pad is pulled low, so only enabled ones show the level
    assign pad_o = {hi_out_i & hi_oe_i, lo_out_i & lo_oe_i};
    assign strap_o = STRAP;
endmodule

// ===== test/gob_bank_properties.sv
// assertions on the output bank registers
// sees only bank ports; one clock, synchronous reset
`timescale 1ns/10ps
module gob_bank_properties
    import gob_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // reset
    input wire logic ce_i, // enable
    input wire logic psel_i, // select
    input wire logic penable_i, // access
    input wire logic pwrite_i, // write
    input wire logic [7:0] paddr_i, // address
    input wire logic [31:0] pwdata_i, // data
    input wire logic pready_o, // ready
    input wire logic [31:0] lo_out_o, // levels
    input wire logic [31:0] lo_oe_o, // enables
    input wire logic [7:0] hi_out_o, // levels high
    input wire logic [7:0] hi_oe_o // enables high
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // a write taken at this edge
    sequence s_w(logic [7:0] a);
        psel_i && penable_i && pwrite_i && !pready_o && ce_i && paddr_i == a;
    endsequence
    property p_rdy; psel_i && penable_i && !pready_o && ce_i |=> pready_o; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_lo; s_w(GOB_OFS_LO_OUT) |=> lo_out_o == $past(pwdata_i); endproperty
    a_lo: assert property (p_lo) else $error("lo write");
    property p_los; s_w(GOB_OFS_LO_OUT_SET) |=> lo_out_o == ($past(lo_out_o) | $past(pwdata_i)); endproperty
    a_los: assert property (p_los) else $error("lo set");
    property p_loc; s_w(GOB_OFS_LO_OUT_CLR) |=> lo_out_o == ($past(lo_out_o) & ~$past(pwdata_i)); endproperty
    a_loc: assert property (p_loc) else $error("lo clear");
    property p_his; s_w(GOB_OFS_HI_OUT_SET) |=> hi_out_o == ($past(hi_out_o) | $past(pwdata_i[7:0])); endproperty
    a_his: assert property (p_his) else $error("hi set");
    property p_hic; s_w(GOB_OFS_HI_OUT_CLR) |=> hi_out_o == ($past(hi_out_o) & ~$past(pwdata_i[7:0])); endproperty
    a_hic: assert property (p_hic) else $error("hi clear");
    property p_oes; s_w(GOB_OFS_LO_OE_SET) |=> lo_oe_o == ($past(lo_oe_o) | $past(pwdata_i)); endproperty
    a_oes: assert property (p_oes) else $error("oe set");
    property p_oec; s_w(GOB_OFS_LO_OE_CLR) |=> lo_oe_o == ($past(lo_oe_o) & ~$past(pwdata_i)); endproperty
    a_oec: assert property (p_oec) else $error("oe clear");
    property p_hi; s_w(GOB_OFS_HI_OUT) |=> hi_out_o == $past(pwdata_i[7:0]); endproperty
    a_hi: assert property (p_hi) else $error("hi write");
    property p_oe; s_w(GOB_OFS_LO_OE) |=> lo_oe_o == $past(pwdata_i); endproperty
    a_oe: assert property (p_oe) else $error("oe write");
    property p_hoe; s_w(GOB_OFS_HI_OE) |=> hi_oe_o == $past(pwdata_i[7:0]); endproperty
    a_hoe: assert property (p_hoe) else $error("hi oe write");
    property p_hoes; s_w(GOB_OFS_HI_OE_SET) |=> hi_oe_o == ($past(hi_oe_o) | $past(pwdata_i[7:0])); endproperty
    a_hoes: assert property (p_hoes) else $error("hi oe set");
    property p_hoec; s_w(GOB_OFS_HI_OE_CLR) |=> hi_oe_o == ($past(hi_oe_o) & ~$past(pwdata_i[7:0])); endproperty
    a_hoec: assert property (p_hoec) else $error("hi oe clear");
endmodule
bind gob_bank gob_bank_properties gob_bank_properties_i (.*);

// ===== test/testbench.sv
// self-checking bench for the output bank over apb
// assumes the pad model gives the strap levels
`timescale 1ns/10ps
module testbench;
    import gob_pkg::*;
    logic clk_i = 1'h0, rst_n_i = 1'h0, ce_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic [7:0] paddr_i = 8'h00, hi_out_o, hi_oe_o, base [4] = '{8'h04, 8'h10, 8'h20, 8'h2c};
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, lo_out_o, lo_oe_o, r, m;
    logic pready_o, pslverr_o, e, strap_tdi_i, strap_p0_i, strap_p2_i, strap_p4_i, strap_tdo_i, strap_p5_i;
    logic [39:0] pad;
    int n_mismatch = 0, tests_run = 0;
    gob_bank gob_bank_i (.*);
    gob_pad_model gob_pad_model_i (.lo_out_i(lo_out_o), .lo_oe_i(lo_oe_o), .hi_out_i(hi_out_o),
        .hi_oe_i(hi_oe_o), .pad_o(pad), .strap_o({strap_tdi_i, strap_p0_i, strap_p2_i, strap_p4_i,
        strap_tdo_i, strap_p5_i}));
    always #20 clk_i = ~clk_i;
    // one apb transfer; idles a cycle after so psel never toggles twice in a step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'h1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'h1 && n < 16);
        if (n >= 16) begin
            n_mismatch++;
            $display("Error at %0t: no ready", $time);
        end
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // write one place, read back the same or another, expect no error
    task automatic step(input logic [7:0] a, input logic [7:0] wa, input logic [31:0] d, input logic [31:0] x);
        xfer(1'h1, wa, d);
        xfer(1'h0, a, 32'h0000_0000);
        chk({e, r}, {1'h0, x});
    endtask
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'h1;
        @(posedge clk_i);
        chk({hi_oe_o, hi_out_o, lo_oe_o, lo_out_o}, 80'h0);
        step(GOB_OFS_STRAP, GOB_OFS_STRAP, 32'hffff_ffff, 32'h0000_002d);
        for (int i = 0; i < 4; i++) begin
            m = i[0] ? 32'h0000_00ff : 32'hffff_ffff;
            step(base[i], base[i], 32'ha5a5_5a5a, m & 32'ha5a5_5a5a);
            step(base[i], base[i] + 8'h04, 32'h0f0f_0f0f, m & 32'hafaf_5f5f);
            step(base[i], base[i] + 8'h08, 32'h3c3c_3c3c, m & 32'h8383_4343);
            step(base[i] + 8'h08, base[i] + 8'h04, 32'h0000_0000, 32'h0000_0000);
        end
        chk({hi_oe_o, hi_out_o, lo_oe_o, lo_out_o}, {16'h4343, 64'h8383_4343_8383_4343});
        chk(pad, {8'h43, 32'h8383_4343});
        xfer(1'h1, 8'h1c, 32'hffff_ffff);
        chk({e, r, lo_out_o}, {1'h1, 64'h0000_0000_8383_4343});
        // a low clock enable holds off both the answer and the write
        ce_i <= 1'h0;
        fork
            xfer(1'h1, GOB_OFS_LO_OUT, 32'h0000_0000);
            begin
                repeat (4) @(posedge clk_i);
                chk({31'h0, pready_o, lo_out_o}, {32'h0, 32'h8383_4343});
                ce_i <= 1'h1;
            end
        join
        chk(lo_out_o, 32'h0000_0000);
        finish_test;
    end
    // cuts a hang short
    initial begin
        repeat (4000) @(posedge clk_i);
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test;
    end
endmodule
